/* design/qpio_pkg.sv */
/*
  Shared constants for the quad port I/O block: register map, reset values,
  bit positions of the shared pins.
  Assumes the CPU side addresses data memory with an 8-bit byte address.
*/
package qpio_pkg;
  localparam int QP_NUM_PORTS = 4;
  localparam int QP_WIDTH = 8;
  // Data latches at even addresses, direction registers one above each
  localparam logic [7:0] QP_ADDR_PORT_A = 8'h12;
  localparam logic [7:0] QP_ADDR_DIR_A = 8'h13;
  localparam logic [7:0] QP_ADDR_PORT_B = 8'h14;
  localparam logic [7:0] QP_ADDR_DIR_B = 8'h15;
  localparam logic [7:0] QP_ADDR_PORT_C = 8'h16;
  localparam logic [7:0] QP_ADDR_DIR_C = 8'h17;
  localparam logic [7:0] QP_ADDR_PORT_D = 8'h18;
  localparam logic [7:0] QP_ADDR_DIR_D = 8'h19;
  localparam logic [7:0] QP_LATCH_ADDR [QP_NUM_PORTS] =
    '{QP_ADDR_PORT_A, QP_ADDR_PORT_B, QP_ADDR_PORT_C, QP_ADDR_PORT_D};
  localparam logic [7:0] QP_DIR_ADDR [QP_NUM_PORTS] =
    '{QP_ADDR_DIR_A, QP_ADDR_DIR_B, QP_ADDR_DIR_C, QP_ADDR_DIR_D};
  // Reset values: all lines input, latches cleared
  localparam logic [7:0] QP_DIR_RESET = 8'hFF;
  localparam logic [7:0] QP_LATCH_RESET = 8'h00;
  localparam logic [7:0] QP_UNMAPPED_READ = 8'h00;
  // Port indices
  localparam int QP_PA = 0;
  localparam int QP_PB = 1;
  localparam int QP_PD = 3;
  // Shared-pin bit positions
  localparam int QP_BIT_BZ = 0;
  localparam int QP_BIT_NBZ = 1;
  localparam int QP_BIT_PFD = 3;
  localparam int QP_PWM_LINES = 4;
  localparam int QP_BIT_IRQ0 = 4;
  localparam int QP_BIT_IRQ1 = 5;
  localparam int QP_BIT_TIMER0_EVENT_IN = 6;
  localparam int QP_BIT_TIMER1_EVENT_IN = 7;
endpackage : qpio_pkg

/* design/qpio_ports.sv */
/*
  Four 8-bit bidirectional ports with data latch, direction register,
  read view, pad drive and the alternate outputs shared onto pins.
  Assumes pads arrive asynchronously, the timer, buzzer and pulse-width
  sources run on clk_sys, and option inputs are static during operation.
*/
// Behaviour
// - Four 8-bit data latches at even addresses 12h through 18h.
// - Port input is not latched; a read samples the pads at read time. Here a read sees the pads through the two-stage synchroniser, two edges late.
// - Written output values stay in the latch until rewritten.
// - One direction bit per line: one is input, zero push-pull output.
// - Read returns pad for input bits, latch for output bits.
// - Direction registers sit at odd addresses right after each latch.
// - After reset every line is input, pulled high or floating.
// - Bit operations read whole port, modify, write back.
// - Every port A line may wake the device when selected. Here only a selected line whose direction bit sets it as input wakes it.
// - Divider option: line A3 output carries divider if latch one, else low.
// - Divider toggles on each timer overflow, halving overflow rate.
// - A shared pin in input mode stays an ordinary logic input.
// - Buzzer option: A0 and A1 outputs carry buzzer, gated by latch.
// - A1 drives inverse buzzer only when A0 is buzzer output; follows A0 latch.
// - Pulse-width option: D0 to D3 outputs carry channels gated by latch.
// - D4 to D7 feed two external interrupts and two timer event inputs.
// - Port B analog input lines lose digital function and pull-high.
`timescale 1ns/100ps
module qpio_ports
  import qpio_pkg::*;
(
  input wire logic clk_sys, // System clock, 25 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic [7:0] cpu_addr, // Data-memory byte address
  input wire logic cpu_wr, // Write strobe
  input wire logic [7:0] cpu_wdata, // Write data
  input wire logic cpu_rd, // Read strobe
  output logic [7:0] cpu_rdata, // Read data, registered
  output logic cpu_rvalid, // Read data valid pulse
  input wire logic [7:0] pad_a_in, // Port A pad levels
  output logic [7:0] pad_a_out, // Port A drive value
  output logic [7:0] pad_a_oe_n, // Port A drive enable, low drives
  input wire logic [7:0] pad_b_in, // Port B pad levels
  output logic [7:0] pad_b_out, // Port B drive value
  output logic [7:0] pad_b_oe_n, // Port B drive enable, low drives
  input wire logic [7:0] pad_c_in, // Port C pad levels
  output logic [7:0] pad_c_out, // Port C drive value
  output logic [7:0] pad_c_oe_n, // Port C drive enable, low drives
  input wire logic [7:0] pad_d_in, // Port D pad levels
  output logic [7:0] pad_d_out, // Port D drive value
  output logic [7:0] pad_d_oe_n, // Port D drive enable, low drives
  input wire logic [7:0] pull_sel_a, // Pull-high option per line
  input wire logic [7:0] pull_sel_b, // Pull-high option per line
  input wire logic [7:0] pull_sel_c, // Pull-high option per line
  input wire logic [7:0] pull_sel_d, // Pull-high option per line
  output logic [7:0] pull_en_a, // Pull-high resistor active
  output logic [7:0] pull_en_b, // Pull-high resistor active
  output logic [7:0] pull_en_c, // Pull-high resistor active
  output logic [7:0] pull_en_d, // Pull-high resistor active
  input wire logic [7:0] wake_sel_a, // Wake-up option per port A line
  output logic wake_event, // Wake-up pulse
  input wire logic [7:0] analog_sel_b, // Port B line used as converter input
  input wire logic pfd_opt, // Divider output option on A3
  input wire logic bz_opt, // Buzzer option on A0
  input wire logic nbz_opt, // Inverse buzzer option on A1
  input wire logic pwm_opt, // Pulse-width option on D0..D3
  input wire logic timer_on, // Timer running
  input wire logic timer_ovf, // Timer overflow pulse
  input wire logic buzzer_in, // Buzzer source
  input wire logic [3:0] pwm_in, // Pulse-width channels 0..3
  output logic freq_divider_out, // Divider signal, registered
  output logic ext_irq0_n, // External interrupt 0, active low
  output logic ext_irq1_n, // External interrupt 1, active low
  output logic timer0_event_in, // Timer 0 event input
  output logic timer1_event_in // Timer 1 event input
);
  typedef logic [QP_WIDTH-1:0] qpio_byte_t;

  qpio_byte_t latch_r [QP_NUM_PORTS];
  qpio_byte_t dir_r [QP_NUM_PORTS];
  qpio_byte_t sync1_r [QP_NUM_PORTS];
  qpio_byte_t sync2_r [QP_NUM_PORTS];
  qpio_byte_t pad_in [QP_NUM_PORTS];
  qpio_byte_t pull_sel [QP_NUM_PORTS];
  qpio_byte_t view [QP_NUM_PORTS];
  qpio_byte_t out_nxt [QP_NUM_PORTS];
  qpio_byte_t oen_nxt [QP_NUM_PORTS];
  qpio_byte_t pull_nxt [QP_NUM_PORTS];
  qpio_byte_t out_r [QP_NUM_PORTS];
  qpio_byte_t oen_r [QP_NUM_PORTS];
  qpio_byte_t pull_r [QP_NUM_PORTS];
  qpio_byte_t wake_prev_r;
  qpio_byte_t rdata_nxt;
  logic pfd_r;
  logic wake_r;
  logic rvalid_r;
  qpio_byte_t rdata_r;

  assign pad_in = '{pad_a_in, pad_b_in, pad_c_in, pad_d_in};
  assign pull_sel = '{pull_sel_a, pull_sel_b, pull_sel_c, pull_sel_d};

  // Latch and direction writes; one register per address
  always_ff @(posedge clk_sys) begin
    for (int p = 0; p < QP_NUM_PORTS; p++) begin
      if (reset) begin
        latch_r[p] <= QP_LATCH_RESET;
        dir_r[p] <= QP_DIR_RESET;
      end else if (cpu_wr) begin
        if (cpu_addr == QP_LATCH_ADDR[p])
          latch_r[p] <= cpu_wdata;
        if (cpu_addr == QP_DIR_ADDR[p])
          dir_r[p] <= cpu_wdata;
      end
    end
  end

  // Two-stage pad synchroniser; only the second stage is read.
  // Stages reset to the idle high level of a pulled-up pad, so the active-low
  // interrupt lines and the wake detector see no false edge after reset
  always_ff @(posedge clk_sys) begin
    for (int p = 0; p < QP_NUM_PORTS; p++) begin
      if (reset) begin
        sync1_r[p] <= 8'hFF;
        sync2_r[p] <= 8'hFF;
      end else begin
        sync1_r[p] <= pad_in[p];
        sync2_r[p] <= sync1_r[p];
      end
    end
  end

  // Read view: pad for inputs, latch for outputs, so read-modify-write
  // keeps output bits intact even when a pad is loaded down
  always_comb begin
    for (int p = 0; p < QP_NUM_PORTS; p++) begin
      for (int b = 0; b < QP_WIDTH; b++) begin
        view[p][b] = dir_r[p][b] ? sync2_r[p][b] : latch_r[p][b];
      end
    end
    // Analog lines carry no digital read value
    view[QP_PB] = view[QP_PB] & ~analog_sel_b;
  end

  // Read decode; input bits come from the second synchroniser stage, the pad as sampled two edges before the strobe's edge
  always_comb begin
    rdata_nxt = QP_UNMAPPED_READ;
    for (int p = 0; p < QP_NUM_PORTS; p++) begin
      if (cpu_addr == QP_LATCH_ADDR[p])
        rdata_nxt = view[p];
      if (cpu_addr == QP_DIR_ADDR[p])
        rdata_nxt = dir_r[p];
    end
  end

  // Read answer register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= cpu_rd;
      if (cpu_rd)
        rdata_r <= rdata_nxt;
    end
  end

  // Divider toggles per overflow; frozen while the timer is off
  always_ff @(posedge clk_sys) begin
    if (reset)
      pfd_r <= 1'b0;
    else if (timer_on && timer_ovf)
      pfd_r <= ~pfd_r;
  end

  // Pad drive: plain latch value, then alternate sources gated by latch
  always_comb begin
    for (int p = 0; p < QP_NUM_PORTS; p++) begin
      out_nxt[p] = latch_r[p];
      oen_nxt[p] = dir_r[p];
      pull_nxt[p] = pull_sel[p] & dir_r[p];
    end
    if (pfd_opt)
      out_nxt[QP_PA][QP_BIT_PFD] = latch_r[QP_PA][QP_BIT_PFD] & pfd_r;
    if (bz_opt)
      out_nxt[QP_PA][QP_BIT_BZ] = latch_r[QP_PA][QP_BIT_BZ] & buzzer_in;
    // Inverse line needs its partner in buzzer output mode
    if (nbz_opt && bz_opt && !dir_r[QP_PA][QP_BIT_BZ])
      out_nxt[QP_PA][QP_BIT_NBZ] = latch_r[QP_PA][QP_BIT_BZ] & ~buzzer_in;
    if (pwm_opt) begin
      for (int b = 0; b < QP_PWM_LINES; b++)
        out_nxt[QP_PD][b] = latch_r[QP_PD][b] & pwm_in[b];
    end
    oen_nxt[QP_PB] = oen_nxt[QP_PB] | analog_sel_b;
    pull_nxt[QP_PB] = pull_nxt[QP_PB] & ~analog_sel_b;
  end

  // Registered pad drive; reset releases every line
  always_ff @(posedge clk_sys) begin
    for (int p = 0; p < QP_NUM_PORTS; p++) begin
      if (reset) begin
        out_r[p] <= 8'h00;
        oen_r[p] <= 8'hFF;
        pull_r[p] <= 8'h00;
      end else begin
        out_r[p] <= out_nxt[p];
        oen_r[p] <= oen_nxt[p];
        pull_r[p] <= pull_nxt[p];
      end
    end
  end

  // Wake on any level change of a selected port A input line;
  // the previous level starts where the synchroniser starts
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wake_prev_r <= 8'hFF;
      wake_r <= 1'b0;
    end else begin
      wake_prev_r <= sync2_r[QP_PA];
      wake_r <= |(wake_sel_a & dir_r[QP_PA] & (sync2_r[QP_PA] ^ wake_prev_r));
    end
  end

  assign cpu_rdata = rdata_r;
  assign cpu_rvalid = rvalid_r;
  assign pad_a_out = out_r[0];
  assign pad_b_out = out_r[1];
  assign pad_c_out = out_r[2];
  assign pad_d_out = out_r[3];
  assign pad_a_oe_n = oen_r[0];
  assign pad_b_oe_n = oen_r[1];
  assign pad_c_oe_n = oen_r[2];
  assign pad_d_oe_n = oen_r[3];
  assign pull_en_a = pull_r[0];
  assign pull_en_b = pull_r[1];
  assign pull_en_c = pull_r[2];
  assign pull_en_d = pull_r[3];
  assign wake_event = wake_r;
  assign freq_divider_out = pfd_r;
  // Upper port D lines feed interrupt and event logic, input mode or not
  assign ext_irq0_n = sync2_r[QP_PD][QP_BIT_IRQ0];
  assign ext_irq1_n = sync2_r[QP_PD][QP_BIT_IRQ1];
  assign timer0_event_in = sync2_r[QP_PD][QP_BIT_TIMER0_EVENT_IN];
  assign timer1_event_in = sync2_r[QP_PD][QP_BIT_TIMER1_EVENT_IN];

  // Checks on the block's own outputs and on the port C latch register
  a_latch_write: assert property (@(posedge clk_sys) disable iff (reset)
    cpu_wr && cpu_addr == QP_ADDR_PORT_C ##1 cpu_rd && cpu_addr == QP_ADDR_PORT_C
    && dir_r[2] == 8'h00 |=> cpu_rdata == $past(cpu_wdata, 2))
    else $error("port C latch readback wrong");
  a_dir_write: assert property (@(posedge clk_sys) disable iff (reset)
    cpu_wr && cpu_addr == QP_ADDR_DIR_B |=> ##1 pad_b_oe_n ==
    ($past(cpu_wdata, 2) | $past(analog_sel_b)))
    else $error("port B direction not applied");
  a_read_mux: assert property (@(posedge clk_sys) disable iff (reset)
    cpu_rd && cpu_addr == QP_ADDR_PORT_A |=> cpu_rvalid &&
    cpu_rdata == (($past(dir_r[0]) & $past(sync2_r[0])) | (~$past(dir_r[0]) & $past(latch_r[0]))))
    else $error("port A read view wrong");
  // Reset must leave ports A and D undriven and no read answer one edge later
  a_reset_input: assert property (@(posedge clk_sys)
    reset |=> pad_a_oe_n == 8'hFF && pad_d_oe_n == 8'hFF && !cpu_rvalid)
    else $error("lines not input after reset");
  a_latch_hold: assert property (@(posedge clk_sys) disable iff (reset)
    !(cpu_wr && cpu_addr == QP_ADDR_PORT_C) |=> latch_r[2] == $past(latch_r[2]))
    else $error("latch changed without write");
  a_pfd_pin: assert property (@(posedge clk_sys) disable iff (reset)
    pfd_opt && !dir_r[0][3] |=> pad_a_out[3] == ($past(latch_r[0][3]) & $past(pfd_r)))
    else $error("divider pin wrong");
  a_pfd_toggle: assert property (@(posedge clk_sys) disable iff (reset)
    timer_on && timer_ovf |=> freq_divider_out != $past(freq_divider_out))
    else $error("divider did not toggle");
  a_nbz_follow: assert property (@(posedge clk_sys) disable iff (reset)
    bz_opt && nbz_opt && !dir_r[0][0] |=> pad_a_out[1] ==
    ($past(latch_r[0][0]) & ~$past(buzzer_in)))
    else $error("inverse buzzer wrong");
  a_pwm_gate: assert property (@(posedge clk_sys) disable iff (reset)
    pwm_opt && !latch_r[3][2] |=> !pad_d_out[2])
    else $error("pulse-width line not forced low");
  a_analog_off: assert property (@(posedge clk_sys) disable iff (reset)
    analog_sel_b[4] |=> pad_b_oe_n[4] && !pull_en_b[4])
    else $error("analog line still digital");
  // Wake pulse follows one edge after the synchronised change
  a_wake_edge: assert property (@(posedge clk_sys) disable iff (reset)
    wake_sel_a[5] && dir_r[0][5] && $changed(sync2_r[0][5]) |=> wake_event)
    else $error("wake event missed");
  a_input_keep: assert property (@(posedge clk_sys) disable iff (reset)
    dir_r[0][3] && pfd_opt |=> pad_a_oe_n[3])
    else $error("input pin driven");
  // Interrupt and event lines trail the pad by the two synchroniser stages
  a_irq_route: assert property (@(posedge clk_sys) disable iff (reset)
    !$past(reset) && !$past(reset, 2) |-> ext_irq1_n == $past(pad_d_in[5], 2)
    && timer1_event_in == $past(pad_d_in[7], 2))
    else $error("upper port D routing wrong");

  // Main scenarios that the bench should reach
  c_opt_plain: cover property (@(posedge clk_sys) !bz_opt && !pad_a_oe_n[0]);
  c_read_input: cover property (@(posedge clk_sys) cpu_rd && cpu_addr == QP_ADDR_PORT_A
    && dir_r[0] == 8'hFF);
  c_pfd_out: cover property (@(posedge clk_sys) pfd_opt && !pad_a_oe_n[3] && pad_a_out[3]);
  c_buzzer_pair: cover property (@(posedge clk_sys) !pad_a_oe_n[0] && !pad_a_oe_n[1]
    && pad_a_out[0] && !pad_a_out[1]);
  c_wake: cover property (@(posedge clk_sys) wake_event);
endmodule : qpio_ports

/* tb/qpio_board.sv */
/*
  Board-side model of one 8-bit port pin group: device drive, board parts
  and the pull-high resistor resolve each pad.
  Assumes an active-low device drive enable and the bench clock.
*/
`timescale 1ns/100ps
module qpio_board (
  input wire logic clk_sys, // Bench clock
  input wire logic [7:0] drv_out, // Device drive value
  input wire logic [7:0] drv_oe_n, // Device drive, low drives
  input wire logic [7:0] pull_en, // Pull-high active
  input wire logic [7:0] ext_val, // Level from board parts
  input wire logic ext_en, // Board parts load undriven lines
  output logic [7:0] pad // Resolved pad level
);
  logic [7:0] float_r = 8'h55;
  // A floating line keeps changing so it never passes for a steady level
  always_ff @(posedge clk_sys) begin
    float_r <= ~float_r;
  end
  // Device drive wins, board parts only load lines left as inputs
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!drv_oe_n[i]) begin
        pad[i] = drv_out[i];
      end else if (ext_en) begin
        pad[i] = ext_val[i];
      end else begin
        pad[i] = pull_en[i] ? 1'b1 : float_r[i];
      end
    end
  end
endmodule : qpio_board

/* tb/testbench.sv */
/*
  Self-checking bench for qpio_ports: map, read view, drive, shared pins.
  Assumes one qpio_board on each port; pin options change only between transfers.
*/
`timescale 1ns/100ps
module testbench;
  import qpio_pkg::*;
  logic clk_sys = 1'b0, reset = 1'b1, cpu_wr = 1'b0, cpu_rd = 1'b0, ext_en = 1'b0;
  logic timer_on = 1'b0, timer_ovf = 1'b0, buzzer_in = 1'b0, rv, wk, fdo, seen;
  logic [7:0] cpu_addr = 8'h00, cpu_wdata = 8'h00, ana = 8'h00, rd, t;
  logic [7:0] pull_sel = 8'hFF, wake_sel = 8'hFF;
  logic [3:0] pwm_in = 4'h0, irq, opt = 4'hF;
  wire [7:0] pin [4], po [4], oe [4], pe [4];
  logic [7:0] ext [4], lat [4], dr [4];
  logic [7:0] exq [$];
  logic [31:0] seed = 32'h00014F0C;
  int n_fail = 0, cmp_count = 0, nf = 0;
  qpio_ports dut (
    .clk_sys, .reset, .cpu_addr, .cpu_wr, .cpu_wdata, .cpu_rd, .cpu_rdata(rd),
    .cpu_rvalid(rv), .pad_a_in(pin[0]), .pad_a_out(po[0]), .pad_a_oe_n(oe[0]),
    .pad_b_in(pin[1]), .pad_b_out(po[1]), .pad_b_oe_n(oe[1]),
    .pad_c_in(pin[2]), .pad_c_out(po[2]), .pad_c_oe_n(oe[2]),
    .pad_d_in(pin[3]), .pad_d_out(po[3]), .pad_d_oe_n(oe[3]),
    .pull_sel_a(pull_sel), .pull_sel_b(pull_sel), .pull_sel_c(pull_sel),
    .pull_sel_d(pull_sel), .pull_en_a(pe[0]), .pull_en_b(pe[1]), .pull_en_c(pe[2]),
    .pull_en_d(pe[3]), .wake_sel_a(wake_sel), .wake_event(wk), .analog_sel_b(ana),
    .pfd_opt(opt[0]), .bz_opt(opt[1]), .nbz_opt(opt[2]), .pwm_opt(opt[3]), .timer_on,
    .timer_ovf, .buzzer_in, .pwm_in, .freq_divider_out(fdo), .ext_irq0_n(irq[0]),
    .ext_irq1_n(irq[1]), .timer0_event_in(irq[2]), .timer1_event_in(irq[3])
  );
  for (genvar g = 0; g < 4; g++) begin : g_brd
    qpio_board brd (.clk_sys, .drv_out(po[g]), .drv_oe_n(oe[g]), .pull_en(pe[g]),
      .ext_val(ext[g]), .ext_en, .pad(pin[g]));
  end
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd
  // Port B converter lines read as zero whatever their direction
  function automatic logic [7:0] view(input int i);
    return (i == 1 ? ~ana : 8'hFF) & ((dr[i] & ext[i]) | (~dr[i] & lat[i]));
  endfunction : view
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  // One bus cycle; the read note is taken before the write lands, as the bus orders it
  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    int i;
    i = (int'(a) - 18) / 2;
    cpu_wr = w;
    cpu_rd = r;
    cpu_addr = a;
    cpu_wdata = d;
    if (a >= 8'h12 && a <= 8'h19) begin
      if (r) exq.push_back(a[0] ? dr[i] : view(i));
      if (w && a[0]) dr[i] = d;
      if (w && !a[0]) lat[i] = d;
    end else if (r) begin
      exq.push_back(QP_UNMAPPED_READ);
    end
    tick(1);
  endtask : op
  task automatic idle();
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    tick(1);
  endtask : idle
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out
  // Each read answer retires the oldest note; an answer with no note is a fault.
  // Looked at mid-cycle, where the registered answer has settled
  always @(negedge clk_sys) begin
    if (rv === 1'b1) begin
      if (exq.size() > 0) check(rd, exq.pop_front());
      else check({7'h00, rv}, 8'h00);
    end
  end
  initial begin
    int k;
    for (k = 0; k < 4; k++) begin
      ext[k] = 8'hFF;
      lat[k] = QP_LATCH_RESET;
      dr[k] = QP_DIR_RESET;
    end
    wake_sel = rnd() | 8'h20;
    repeat (4) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    for (k = 0; k < 4; k++) begin
      check(oe[k], 8'hFF);
      check(po[k], 8'h00);
    end
    tick(4);
    for (k = 0; k < 4; k++) begin
      check(pe[k], pull_sel);
      op(1'b0, 1'b1, QP_LATCH_ADDR[k], 8'h00);
      op(1'b0, 1'b1, QP_DIR_ADDR[k], 8'h00);
    end
    ext_en = 1'b1;
    // Odd rounds write only the port C latch, with its inverted read view, while the pads move
    for (k = 0; k < 6; k++) begin
      ana = rnd();
      for (int i = 0; i < 4; i++) ext[i] = rnd();
      for (int i = 0; i < 4 && k % 2 == 0; i++) begin
        op(1'b1, 1'b0, QP_LATCH_ADDR[i], rnd());
        op(1'b1, 1'b0, QP_DIR_ADDR[i], rnd());
      end
      if (k % 2 == 1) op(1'b1, 1'b0, QP_ADDR_PORT_C, ~view(2));
      op(1'b1, 1'b0, 8'h11, rnd());
      idle();
      tick(4);
      for (int i = 0; i < 4; i++) begin
        op(1'b0, 1'b1, QP_LATCH_ADDR[i], 8'h00);
        op(1'b0, 1'b1, QP_DIR_ADDR[i], 8'h00);
      end
      op(1'b0, 1'b1, 8'h1A, 8'h00);
      idle();
      for (int i = 0; i < 4; i++) begin
        check(oe[i], dr[i] | (i == 1 ? ana : 8'h00));
        check(pe[i], pull_sel & dr[i] & (i == 1 ? ~ana : 8'hFF));
      end
      check(po[2], lat[2]);
    end
    // Buzzer pair and divider: latch gates, A0 direction decides A1
    for (k = 0; k < 6; k++) begin
      op(1'b1, 1'b0, QP_ADDR_DIR_A, (k % 3 == 2) ? 8'h01 : 8'h00);
      op(1'b1, 1'b0, QP_ADDR_PORT_A, (k % 3 == 0) ? 8'h09 : ((k % 3 == 1) ? 8'h08 : 8'h02));
      timer_on = (k < 4);
      timer_ovf = 1'b1;
      nf = nf + timer_on;
      idle();
      timer_ovf = 1'b0;
      for (int j = 0; j < 4; j++) begin
        t = rnd();
        buzzer_in = t[0];
        tick(1);
        if (dr[0][0]) check({6'h00, oe[0][0], po[0][1]}, {7'h01, lat[0][1]});
        else check({6'h00, po[0][1:0]}, {6'h00, lat[0][0] & ~buzzer_in, lat[0][0] & buzzer_in});
      end
      check({7'h00, fdo}, {7'h00, nf[0]});
      check({7'h00, po[0][3]}, {7'h00, lat[0][3] & nf[0]});
    end
    // D0..D3 carry gated channels while D4..D7 stay inputs
    op(1'b1, 1'b0, QP_ADDR_DIR_D, 8'hF0);
    op(1'b1, 1'b0, QP_ADDR_PORT_D, rnd());
    idle();
    for (k = 0; k < 6; k++) begin
      t = rnd();
      pwm_in = t[7:4];
      ext[3] = rnd();
      tick(4);
      check({4'h0, po[3][3:0]}, {4'h0, lat[3][3:0] & pwm_in});
      check({4'h0, irq}, {4'h0, ext[3][7:4]});
    end
    // Options off on even rounds: a deselected source leaves the plain latch on the pin
    op(1'b1, 1'b0, QP_ADDR_DIR_A, 8'h00);
    op(1'b1, 1'b0, QP_ADDR_DIR_D, 8'h00);
    for (k = 0; k < 4; k++) begin
      t = rnd();
      opt = k[0] ? t[3:0] : 4'h0;
      buzzer_in = t[4];
      pwm_in = t[7:4];
      op(1'b1, 1'b0, QP_ADDR_PORT_A, rnd());
      op(1'b1, 1'b0, QP_ADDR_PORT_D, rnd());
      idle();
      tick(1);
      t = lat[0];
      if (opt[1]) t[0] = lat[0][0] & buzzer_in;
      if (opt[1] && opt[2]) t[1] = lat[0][0] & ~buzzer_in;
      if (opt[0]) t[3] = lat[0][3] & nf[0];
      check(po[0], t);
      check({4'h0, po[3][3:0]}, {4'h0, lat[3][3:0] & (opt[3] ? pwm_in : 4'hF)});
    end
    // Unused port C parked as outputs; a read right after a write sees the new latch
    op(1'b1, 1'b0, QP_ADDR_DIR_C, 8'h00);
    op(1'b1, 1'b0, QP_ADDR_PORT_C, rnd());
    op(1'b0, 1'b1, QP_ADDR_PORT_C, 8'h00);
    op(1'b1, 1'b0, QP_ADDR_DIR_A, 8'hFF);
    idle();
    tick(8);
    ext[0] = ext[0] ^ 8'h20;
    seen = 1'b0;
    for (k = 0; k < 6; k++) begin
      tick(1);
      if (wk === 1'b1) seen = 1'b1;
    end
    check({7'h00, seen}, 8'h01);
    tick(2);
    check(8'(exq.size()), 8'h00);
    close_out();
  end
endmodule : testbench
